// ===== hdl/flash_ctl_defs.svh
// Constants for the flash suspend and reset control block
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

`define OP_READ        8'h03
`define OP_WRITE_LATCH_SET 8'h06
`define OP_RESUME      8'h30
`define OP_NOP         8'h00
`define OP_RST_ARM     8'h66
`define OP_RST         8'h99
`define OP_TABLE_READ  8'h5A
`define OP_PRG_SUSP    8'hB0
`define OP_ERS_SUSP    8'h75
`define OP_PERF_ON     8'hEB
`define OP_PERF_OFF    8'hFF
`define OP_PROGRAM     8'h02
`define OP_ERASE       8'h20

`define CLK_MHZ        100
`define RESET_PULSE_US 10
`define RESET_PULSE_CYC (`RESET_PULSE_US * `CLK_MHZ)
`define TABLE_HDR_BITS 32
`define SPI_BITS       8
`define QUAD_NIBBLES   2

`endif

// ===== hdl/flash_ctl_pkg.sv
// Types for the flash suspend and reset control block
package flash_ctl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPCODE = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_IGNORE = 3'b100
   } frame_state_t;

   typedef struct packed {
      logic write_enable_latch;
      logic write_in_progress_flag;
      logic program_suspended_flag;
      logic erase_suspended_flag;
   } status_t;

endpackage : flash_ctl_pkg

// ===== hdl/flash_suspend_reset_control.sv
// Command control logic for suspend, resume, reset and table read
//
// Functional notes
// - Suspended region reads flagged invalid
// - Suspend clears latch, filters commands
// - Program suspended flag set and cleared
// - Resume opcode 30h restarts write
// - Resume needs no write latch
// - Busy stays set after resume
// - Resume ignored in performance mode
// - No-op, like any opcode but 66h, cancels reset arm
// - One-byte opcodes, SPI or quad
// - Reset only directly after arm
// - Software reset restores power-on state
// - Software reset aborts program or erase
// - Host waits recovery after reset
// - Table read: opcode, address, dummy
// - Reset pin low 10 us resets
// - Pin reset restores defaults, 3-byte
// - Pin reset aborts, output hi-z
// - Power-up into standby, latch clear
// - Erase suspended flag set and cleared
// - Erase suspend delayed by latency
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"

module flash_suspend_reset_control
   import flash_ctl_pkg::*;
#(
   parameter int RESET_PULSE_CYC = `RESET_PULSE_CYC, // Pin reset filter
   parameter int ERASE_SUSP_CYC = 16, // Erase suspend latency
   parameter int OP_TIME_CYC = 64 // Internal write duration
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Power-on reset
   input wire logic cs_n, // Chip select pin
   input wire logic sclk, // Serial clock pin
   input wire logic [3:0] sio_in, // Data lanes in
   input wire logic quad_command_mode, // Quad command mode
   input wire logic reset_n, // Reset pin
   input wire logic [7:0] table_data, // Table byte at address
   input wire logic [23:0] suspend_region, // Address of suspended region
   output logic [23:0] table_addr, // Table address
   output logic so_out, // Serial output
   output logic so_oe, // Serial output enable
   output logic [3:0] status_bits, // Status flags
   output logic perf_mode, // Performance enhance mode
   output logic addr_4byte, // Four-byte addressing
   output logic read_invalid, // Read hits suspended region
   output logic op_aborted, // Write aborted by reset
   output logic reset_armed // Reset arm pending
);

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [1:0] cs_s_q, ck_s_q, rs_s_q;
   logic [3:0] d0_q, d1_q;
   logic ck_prev_q;
   always_ff @(posedge clk_sys) begin
      cs_s_q <= {cs_s_q[0], cs_n};
      ck_s_q <= {ck_s_q[0], sclk};
      rs_s_q <= {rs_s_q[0], reset_n};
      d0_q <= sio_in;
      d1_q <= d0_q;
      ck_prev_q <= ck_s_q[1];
   end
   wire cs_act = ~cs_s_q[1];
   wire ck_rise = ck_s_q[1] & ~ck_prev_q;
   wire ck_fall = ~ck_s_q[1] & ck_prev_q;

   // ------------------------------------------------------------
   // Pin reset filter
   // ------------------------------------------------------------
   logic [31:0] rlow_q;
   logic pin_rst_q;
   always_ff @(posedge clk_sys) begin
      if (rst || rs_s_q[1]) begin
         rlow_q <= '0;
         pin_rst_q <= 1'b0;
      end else if (rlow_q < 32'(RESET_PULSE_CYC - 1)) begin
         rlow_q <= rlow_q + 32'd1;
      end else begin
         pin_rst_q <= 1'b1;
      end
   end
   wire pin_low = ~rs_s_q[1];

   // ------------------------------------------------------------
   // Frame decoding
   // ------------------------------------------------------------
   frame_state_t st_q;
   logic [7:0] sh_q, op_q;
   logic [5:0] cnt_q;
   logic [2:0] bit_q;
   logic [7:0] out_q;
   logic byte_done;
   logic sw_rst;
   logic op_strobe;

   function automatic logic [7:0] shift_in(input logic [7:0] s,
         input logic [3:0] d, input logic quad);
      shift_in = quad ? {s[3:0], d} : {s[6:0], d[0]};
   endfunction : shift_in

   wire [5:0] op_len = quad_command_mode ?
      6'(`QUAD_NIBBLES) : 6'(`SPI_BITS);
   assign byte_done = ck_rise && (cnt_q == op_len - 6'd1);
   wire [7:0] op_now = shift_in(sh_q, d1_q, quad_command_mode);
   assign op_strobe = (st_q == ST_OPCODE) && byte_done;

   // Command filter while suspended
   function automatic logic allowed(input logic [7:0] op);
      allowed = (op == `OP_READ) || (op == `OP_RESUME) ||
         (op == `OP_RST_ARM) || (op == `OP_RST) || (op == `OP_NOP) ||
         (op == `OP_TABLE_READ) || (op == `OP_WRITE_LATCH_SET) ||
         (op == `OP_PERF_ON) || (op == `OP_PERF_OFF);
   endfunction : allowed

   status_t st_bits_q;
   wire suspended = st_bits_q.program_suspended_flag |
      st_bits_q.erase_suspended_flag;
   wire op_ok = !suspended || allowed(op_now);
   wire hard_rst = rst | pin_rst_q | sw_rst;
   logic hard_rst_q;
   always_ff @(posedge clk_sys) begin
      hard_rst_q <= hard_rst;
   end

   always_ff @(posedge clk_sys) begin
      if (hard_rst || !cs_act) begin
         st_q <= cs_act ? ST_IGNORE : ST_OPCODE;
         cnt_q <= '0;
         sh_q <= '0;
         op_q <= '0;
      end else if (ck_rise) begin
         sh_q <= shift_in(sh_q, d1_q, quad_command_mode);
         case (st_q)
            ST_OPCODE: begin
               cnt_q <= byte_done ? 6'd0 : cnt_q + 6'd1;
               if (byte_done) begin
                  op_q <= op_now;
                  st_q <= (op_now == `OP_TABLE_READ || op_now == `OP_READ)
                     ? ST_ADDR : ST_IGNORE;
               end
            end
            ST_ADDR: begin
               // three address and one dummy byte
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'd31) begin
                  st_q <= ST_DATA;
               end
            end
            ST_DATA: st_q <= ST_DATA;
            ST_IGNORE: st_q <= ST_IGNORE;
            default: st_q <= ST_IGNORE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Address and table stream
   // ------------------------------------------------------------
   logic [23:0] addr_q;
   always_ff @(posedge clk_sys) begin
      if (hard_rst || !cs_act) begin
         addr_q <= '0;
         bit_q <= '0;
         out_q <= '0;
      end else if (st_q == ST_ADDR && ck_rise && cnt_q < 6'd24) begin
         addr_q <= {addr_q[22:0], d1_q[0]};
      end else if (st_q == ST_DATA && ck_fall) begin
         bit_q <= bit_q + 3'd1;
         if (bit_q == 3'd0) begin
            out_q <= table_data;
         end
         if (bit_q == 3'd7) begin
            addr_q <= addr_q + 24'd1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         so_out <= 1'b0;
         so_oe <= 1'b0;
         table_addr <= '0;
      end else begin
         table_addr <= addr_q;
         so_oe <= cs_act && !pin_low && st_q == ST_DATA &&
            op_q == `OP_TABLE_READ;
         if (ck_fall) begin
            so_out <= (bit_q == 3'd0) ? table_data[7] : out_q[3'd7 - bit_q];
         end
      end
   end

   // ------------------------------------------------------------
   // Reset arm and software reset
   // ------------------------------------------------------------
   logic arm_q;
   logic sw_rst_q;
   always_ff @(posedge clk_sys) begin
      if (rst || pin_rst_q || sw_rst_q) begin
         arm_q <= 1'b0;
         sw_rst_q <= 1'b0;
      end else begin
         sw_rst_q <= op_strobe && arm_q && op_now == `OP_RST;
         if (op_strobe) begin
            arm_q <= (op_now == `OP_RST_ARM);
         end
      end
   end
   assign sw_rst = sw_rst_q;

   // ------------------------------------------------------------
   // Write, suspend and resume
   // ------------------------------------------------------------
   logic prg_q, ers_q, susp_pend_q, resumed_q;
   logic [15:0] op_cnt_q, esl_q;
   logic aborted_q;
   wire cmd = op_strobe && op_ok;

   always_ff @(posedge clk_sys) begin
      if (hard_rst) begin
         st_bits_q <= '0;
         prg_q <= 1'b0;
         ers_q <= 1'b0;
         susp_pend_q <= 1'b0;
         resumed_q <= 1'b0;
         op_cnt_q <= '0;
         esl_q <= '0;
         perf_mode <= 1'b0;
         // Abort seen on the first reset cycle only
         if (rst) begin
            aborted_q <= 1'b0;
         end else if (!hard_rst_q) begin
            aborted_q <= st_bits_q.write_in_progress_flag || suspended;
         end
      end else begin
         resumed_q <= 1'b0;
         if (cmd && op_now == `OP_WRITE_LATCH_SET) begin
            st_bits_q.write_enable_latch <= 1'b1;
         end
         if (cmd && op_now == `OP_PERF_ON && suspended) begin
            perf_mode <= 1'b1;
         end
         if (cmd && op_now == `OP_PERF_OFF) begin
            perf_mode <= 1'b0;
         end
         if (cmd && st_bits_q.write_enable_latch && !suspended &&
               !st_bits_q.write_in_progress_flag &&
               (op_now == `OP_PROGRAM || op_now == `OP_ERASE)) begin
            st_bits_q.write_in_progress_flag <= 1'b1;
            st_bits_q.write_enable_latch <= 1'b0;
            prg_q <= (op_now == `OP_PROGRAM);
            ers_q <= (op_now == `OP_ERASE);
            op_cnt_q <= 16'(OP_TIME_CYC);
         end
         // Internal write countdown
         if (st_bits_q.write_in_progress_flag && !suspended &&
               !susp_pend_q) begin
            if (op_cnt_q <= 16'd1) begin
               st_bits_q.write_in_progress_flag <= 1'b0;
               prg_q <= 1'b0;
               ers_q <= 1'b0;
            end else begin
               op_cnt_q <= op_cnt_q - 16'd1;
            end
         end
         if (cmd && op_now == `OP_PRG_SUSP && prg_q && !suspended) begin
            st_bits_q.program_suspended_flag <= 1'b1;
            st_bits_q.write_enable_latch <= 1'b0;
         end
         if (cmd && op_now == `OP_ERS_SUSP && ers_q && !suspended) begin
            susp_pend_q <= 1'b1;
            esl_q <= 16'(ERASE_SUSP_CYC);
         end else if (susp_pend_q) begin
            if (esl_q <= 16'd1) begin
               susp_pend_q <= 1'b0;
               st_bits_q.erase_suspended_flag <= 1'b1;
               st_bits_q.write_enable_latch <= 1'b0;
            end else begin
               esl_q <= esl_q - 16'd1;
            end
         end
         if (cmd && op_now == `OP_RESUME && suspended && !perf_mode) begin
            st_bits_q.program_suspended_flag <= 1'b0;
            st_bits_q.erase_suspended_flag <= 1'b0;
            resumed_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_bits <= '0;
         addr_4byte <= 1'b0;
         read_invalid <= 1'b0;
         op_aborted <= 1'b0;
         reset_armed <= 1'b0;
      end else begin
         status_bits <= st_bits_q;
         addr_4byte <= 1'b0;
         read_invalid <= suspended && st_q == ST_DATA &&
            addr_q[23:12] == suspend_region[23:12];
         op_aborted <= aborted_q;
         reset_armed <= arm_q;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // busy held after resume
   property p_busy_after_resume;
      @(posedge clk_sys) disable iff (hard_rst)
      resumed_q |-> st_bits_q.write_in_progress_flag;
   endproperty
   a_busy_after_resume: assert property (p_busy_after_resume)
      else $error("busy dropped at resume");

   property p_susp_latch;
      @(posedge clk_sys) disable iff (hard_rst)
      $rose(st_bits_q.program_suspended_flag) |->
         !st_bits_q.write_enable_latch;
   endproperty
   a_susp_latch: assert property (p_susp_latch)
      else $error("latch set on suspend");

   property p_idle_resume;
      @(posedge clk_sys) disable iff (hard_rst)
      (cmd && op_now == `OP_RESUME && !suspended) |=>
         !resumed_q;
   endproperty
   a_idle_resume: assert property (p_idle_resume)
      else $error("resume acted without suspend");

   property p_perf_block;
      @(posedge clk_sys) disable iff (hard_rst)
      (perf_mode && suspended) |=> !resumed_q;
   endproperty
   a_perf_block: assert property (p_perf_block)
      else $error("resume in performance mode");

   property p_rst_after_arm;
      @(posedge clk_sys) disable iff (rst || pin_rst_q)
      $rose(sw_rst_q) |-> $past(arm_q);
   endproperty
   a_rst_after_arm: assert property (p_rst_after_arm)
      else $error("reset without arm");

   property p_hiz_pin;
      @(posedge clk_sys) disable iff (rst)
      pin_low |=> !so_oe;
   endproperty
   a_hiz_pin: assert property (p_hiz_pin)
      else $error("output driven during pin reset");

   property p_esl;
      @(posedge clk_sys) disable iff (hard_rst)
      $rose(susp_pend_q) |-> !st_bits_q.erase_suspended_flag [*2];
   endproperty
   a_esl: assert property (p_esl)
      else $error("erase suspend too early");

   property p_sw_clear;
      @(posedge clk_sys) disable iff (rst || pin_rst_q)
      sw_rst_q |=> st_bits_q == '0 && !perf_mode;
   endproperty
   a_sw_clear: assert property (p_sw_clear)
      else $error("status kept after reset");

endmodule : flash_suspend_reset_control

// ===== test/flash_host_model.sv
// Host flash controller model driving the serial command pins
`timescale 1ns/1ps

module flash_host_model (
   input wire logic clk_sys, // Frame start reference
   input wire logic quad, // Quad command mode
   input wire logic so_out, // Device serial output
   output logic cs_n, // Chip select
   output logic sclk, // Serial clock, idle low
   output logic [3:0] sio_in // Data lanes
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sio_in = 4'hA;
   end

   // -----------------------------------------------------------------
   // Frame tasks
   // -----------------------------------------------------------------
   task automatic frame_open();
      #400;
      @(negedge clk_sys);
      #3;
      cs_n = 1'b0;
      #80;
   endtask : frame_open

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      int n;
      n = quad ? 2 : 8;
      for (int i = 0; i < n; i++) begin
         if (quad) begin
            sio_in = (i == 0) ? tx[7:4] : tx[3:0];
         end else begin
            sio_in = {~sio_in[3:1], tx[7-i]};
         end
         #80;
         sclk = 1'b1;
         rx = {rx[6:0], so_out};
         #80;
         sclk = 1'b0;
      end
   endtask : xfer

   // Released lanes show the inverse of the last value
   task automatic frame_close();
      #80;
      cs_n = 1'b1;
      sio_in = ~sio_in;
   endtask : frame_close

   task automatic op(input logic [7:0] code);
      logic [7:0] rx;
      frame_open();
      xfer(code, rx);
      frame_close();
   endtask : op
endmodule : flash_host_model

// ===== test/flash_suspend_reset_control_tb.sv
// Testbench for the flash suspend and reset control block
`timescale 1ns/1ps
`include "flash_ctl_defs.svh"

module flash_suspend_reset_control_tb;
   logic clk_sys, rst, cs_n, sclk, quad_command_mode, reset_n;
   logic [3:0] sio_in, status_bits;
   logic [7:0] table_data;
   logic [23:0] suspend_region, table_addr;
   logic so_out, so_oe, perf_mode, addr_4byte, read_invalid;
   logic op_aborted, reset_armed;
   int n_mismatch = 0;
   int checks_done = 0;

   assign table_data = table_addr[7:0] ^ 8'h5A;

   flash_suspend_reset_control #(.RESET_PULSE_CYC(20),
      .ERASE_SUSP_CYC(40), .OP_TIME_CYC(2000))
   i_flash_suspend_reset_control (.clk_sys(clk_sys), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
      .quad_command_mode(quad_command_mode), .reset_n(reset_n),
      .table_data(table_data), .suspend_region(suspend_region),
      .table_addr(table_addr), .so_out(so_out), .so_oe(so_oe),
      .status_bits(status_bits), .perf_mode(perf_mode),
      .addr_4byte(addr_4byte), .read_invalid(read_invalid),
      .op_aborted(op_aborted), .reset_armed(reset_armed));

   flash_host_model i_flash_host_model (.clk_sys(clk_sys),
      .quad(quad_command_mode), .so_out(so_out), .cs_n(cs_n),
      .sclk(sclk), .sio_in(sio_in));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic final_report();
      $display("Checks: %0d, mismatches: %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic run(input logic [7:0] code);
      i_flash_host_model.op(code);
      cyc(10);
   endtask : run

   // Read with address; flag looked at while selected
   task automatic rd(input logic [23:0] a, input logic exp);
      logic [7:0] rx;
      i_flash_host_model.frame_open();
      i_flash_host_model.xfer(`OP_READ, rx);
      for (int i = 2; i >= 0; i--) begin
         i_flash_host_model.xfer(a[8*i+:8], rx);
      end
      // Dummy byte: data phase starts after 32 bits
      i_flash_host_model.xfer(8'h00, rx);
      cyc(6);
      chk(read_invalid, exp);
      i_flash_host_model.frame_close();
      cyc(10);
   endtask : rd

   task automatic tbl(input logic [23:0] a, input int n);
      logic [7:0] rx;
      logic [23:0] e;
      i_flash_host_model.frame_open();
      i_flash_host_model.xfer(`OP_TABLE_READ, rx);
      for (int i = 2; i >= 0; i--) begin
         i_flash_host_model.xfer(a[8*i+:8], rx);
      end
      i_flash_host_model.xfer(8'h00, rx);
      for (int k = 0; k < n; k++) begin
         e = a + 24'(k);
         i_flash_host_model.xfer(8'hFF, rx);
         chk(rx, e[7:0] ^ 8'h5A);
      end
      chk(so_oe, 1'b1);
      chk(table_addr, a + 24'(n));
      i_flash_host_model.frame_close();
      cyc(10);
   endtask : tbl

   task automatic wait_idle();
      int i;
      for (i = 0; i < 3000 && status_bits[2] !== 1'b0; i++) begin
         cyc(1);
      end
      if (i == 3000) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, 1, 0);
         final_report();
      end
   endtask : wait_idle

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      quad_command_mode = 1'b0;
      reset_n = 1'b1;
      suspend_region = 24'h012000;
      cyc(8);
      rst = 1'b0;
      cyc(10);
      chk(status_bits, 4'h0);
      chk(addr_4byte, 1'b0);
      run(`OP_WRITE_LATCH_SET);
      chk(status_bits[3], 1'b1);
      run(`OP_PROGRAM);
      chk(status_bits[2], 1'b1);
      run(`OP_WRITE_LATCH_SET);
      chk(status_bits[3], 1'b1);
      run(`OP_PRG_SUSP);
      chk(status_bits[3], 1'b0);
      chk(status_bits[1], 1'b1);
      run(`OP_ERASE);
      chk(status_bits[0], 1'b0);
      rd(24'h012ABC, 1'b1);
      rd(24'h013000, 1'b0);
      run(`OP_PERF_ON);
      chk(perf_mode, 1'b1);
      run(`OP_RESUME);
      chk(status_bits[1], 1'b1);
      run(`OP_PERF_OFF);
      chk(status_bits[3], 1'b0);
      run(`OP_RESUME);
      chk(status_bits[1:0], 2'b00);
      chk(status_bits[2], 1'b1);
      wait_idle();
      run(`OP_RESUME);
      chk(status_bits, 4'h0);
      run(`OP_WRITE_LATCH_SET);
      run(`OP_ERASE);
      run(`OP_ERS_SUSP);
      chk(status_bits[0], 1'b0);
      cyc(60);
      chk(status_bits[0], 1'b1);
      run(`OP_RESUME);
      chk(status_bits[0], 1'b0);
      run(`OP_RST_ARM);
      chk(reset_armed, 1'b1);
      run(`OP_NOP);
      chk(reset_armed, 1'b0);
      chk(status_bits[2], 1'b1);
      quad_command_mode = 1'b1;
      run(`OP_RST_ARM);
      run(`OP_RST);
      chk(status_bits, 4'h0);
      chk(perf_mode, 1'b0);
      chk(op_aborted, 1'b1);
      quad_command_mode = 1'b0;
      cyc(4000);
      run(`OP_RST_ARM);
      run(`OP_WRITE_LATCH_SET);
      run(`OP_RST);
      chk(status_bits[3], 1'b1);
      tbl(24'h0000FE, 3);
      run(`OP_RST_ARM);
      run(`OP_RST);
      chk(status_bits[3], 1'b0);
      chk(op_aborted, 1'b0);
      cyc(4000);
      run(`OP_WRITE_LATCH_SET);
      run(`OP_PROGRAM);
      reset_n = 1'b0;
      cyc(10);
      reset_n = 1'b1;
      cyc(10);
      chk(status_bits[2], 1'b1);
      reset_n = 1'b0;
      cyc(25);
      chk(so_oe, 1'b0);
      reset_n = 1'b1;
      cyc(5);
      chk(status_bits, 4'h0);
      chk(op_aborted, 1'b1);
      cyc(1000);
      run(`OP_WRITE_LATCH_SET);
      chk(status_bits[3], 1'b1);
      final_report();
   end
endmodule : flash_suspend_reset_control_tb
